// >>> verilog/sbot_cfg.svh
// register offsets, field positions, reset values and timing constants of the blink off timer
`ifndef SBOT_CFG_SVH
`define SBOT_CFG_SVH
`define SBOT_ADDR_SINKS1_4 8'h1d
`define SBOT_ADDR_SINK6 8'h1e
`define SBOT_RST_SINKS1_4 8'h00
`define SBOT_RST_SINK6 8'h00
`define SBOT_SINK6_MASK 8'h7f
`define SBOT_CH1_LSB 0
`define SBOT_CH2_LSB 2
`define SBOT_CH3_LSB 4
`define SBOT_CH4_LSB 6
`define SBOT_CLK_NS 10
`define SBOT_TICK_NS 50000000
`define SBOT_TICK_CYCLES (`SBOT_TICK_NS / `SBOT_CLK_NS)
`define SBOT_OFF_06_TICKS 8'h0c
`define SBOT_OFF_12_TICKS 8'h18
`define SBOT_OFF_18_TICKS 8'h24
`define SBOT_CODE_DIS2 2'h0
`define SBOT_CODE_DIS7 7'h00
`define SBOT_CODE_ZERO7 7'h01
`define SBOT_CODE_HOLD7 7'h7f
`endif

// >>> verilog/sbot_pkg.sv
// types shared by the blink off timer modules
package sbot_pkg;
  typedef enum logic [1:0] {SBOT_IDLE, SBOT_ON, SBOT_OFF, SBOT_HOLD} sbot_state_e;
  typedef logic [7:0] sbot_ticks_t;
endpackage

// >>> verilog/sbot_chan.sv
// one sink channel: on phase, off phase, optional hold-off
`timescale 1ns/1ns
`default_nettype none
module sbot_chan (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // time base
  input wire logic tick,
  // channel setup
  input wire logic enable,
  input wire logic [3:0] on_ticks,
  input wire sbot_pkg::sbot_ticks_t off_ticks,
  input wire logic off_dis,
  input wire logic off_hold,
  // sink drive
  output logic sink_on
);
  import sbot_pkg::*;

  sbot_state_e state_r;
  sbot_ticks_t cnt_r;
  logic on_done;
  logic off_done;

  // phase ends once the tick count has reached the target; a zero target ends at once
  assign on_done = (cnt_r >= {4'h0, on_ticks});
  assign off_done = (cnt_r >= off_ticks);
  assign sink_on = (state_r == SBOT_ON);

  // --------------------------------------------------
  // phase sequencer
  // --------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= SBOT_IDLE;
    end else if (!enable) begin
      state_r <= SBOT_IDLE;
    end else begin
      unique case (state_r)
        SBOT_IDLE: begin
          state_r <= SBOT_ON;
        end
        SBOT_ON: begin
          if (!off_dis && on_done) begin
            state_r <= SBOT_OFF;
          end
        end
        SBOT_OFF: begin
          if (off_dis) begin
            state_r <= SBOT_ON;
          end else if (off_hold) begin
            state_r <= SBOT_HOLD;
          end else if (off_done) begin
            state_r <= SBOT_ON;
          end
        end
        SBOT_HOLD: begin
          state_r <= SBOT_HOLD;
        end
      endcase
    end
  end

  // --------------------------------------------------
  // phase tick counter, cleared on every phase change except off to hold
  // --------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
    end else if (!enable || state_r == SBOT_IDLE) begin
      cnt_r <= 8'h00;
    end else if (state_r == SBOT_ON && !off_dis && on_done) begin
      cnt_r <= 8'h00;
    end else if (state_r == SBOT_OFF && (off_dis || off_done)) begin
      cnt_r <= 8'h00;
    end else if (tick && cnt_r != 8'hff) begin
      cnt_r <= cnt_r + 8'h01; // saturates so a long phase cannot wrap
    end
  end
endmodule
`default_nettype wire

// >>> verilog/sbot_top.sv
// blink off timers for sinks one to four and sink six, with their two registers
`timescale 1ns/1ns
`default_nettype none
`include "sbot_cfg.svh"
module sbot_top #(
  parameter int TICK_CYCLES = `SBOT_TICK_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register file port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata,
  // channel controls from neighbouring registers
  input wire logic [4:0] sink_enable,
  input wire logic [3:0] sink_on_duration,
  // sink drive: bits 0..3 are sinks one to four, bit 4 is sink six
  output logic [4:0] sink_on
);
  import sbot_pkg::*;

  logic [7:0] sinks1_4_off_times_r;
  logic [7:0] sink6_off_timer_r;
  logic [7:0] reg_rdata_r;
  logic [31:0] pre_r;
  logic tick;
  logic [1:0] ch1_off_code;
  logic [1:0] ch2_off_code;
  logic [1:0] ch3_off_code;
  logic [1:0] ch4_off_code;
  logic [6:0] ch6_off_code;
  logic [1:0] code2 [4];
  sbot_ticks_t off_ticks [5];
  logic [4:0] off_dis;
  logic [4:0] off_hold;

  // --------------------------------------------------
  // registers
  // --------------------------------------------------
  // writes land one cycle after the strobe; reserved bit of sink six stays zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sinks1_4_off_times_r <= `SBOT_RST_SINKS1_4;
    end else if (reg_wr && reg_addr == `SBOT_ADDR_SINKS1_4) begin
      sinks1_4_off_times_r <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sink6_off_timer_r <= `SBOT_RST_SINK6;
    end else if (reg_wr && reg_addr == `SBOT_ADDR_SINK6) begin
      sink6_off_timer_r <= reg_wdata & `SBOT_SINK6_MASK;
    end
  end

  // read data is registered; unmapped offsets read zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_addr == `SBOT_ADDR_SINKS1_4) begin
      reg_rdata_r <= sinks1_4_off_times_r;
    end else if (reg_addr == `SBOT_ADDR_SINK6) begin
      reg_rdata_r <= sink6_off_timer_r;
    end else begin
      reg_rdata_r <= 8'h00;
    end
  end
  assign reg_rdata = reg_rdata_r;

  // --------------------------------------------------
  // 50 ms time base
  // --------------------------------------------------
  // one tick is the on-time step; off times are whole multiples of it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_r <= 32'h0;
    end else if (pre_r >= 32'(TICK_CYCLES - 1)) begin
      pre_r <= 32'h0;
    end else begin
      pre_r <= pre_r + 32'h1;
    end
  end
  assign tick = (pre_r >= 32'(TICK_CYCLES - 1));

  // --------------------------------------------------
  // field split and decode
  // --------------------------------------------------
  assign ch1_off_code = sinks1_4_off_times_r[`SBOT_CH1_LSB +: 2];
  assign ch2_off_code = sinks1_4_off_times_r[`SBOT_CH2_LSB +: 2];
  assign ch3_off_code = sinks1_4_off_times_r[`SBOT_CH3_LSB +: 2];
  assign ch4_off_code = sinks1_4_off_times_r[`SBOT_CH4_LSB +: 2];
  assign ch6_off_code = sink6_off_timer_r[6:0];
  assign code2[0] = ch1_off_code;
  assign code2[1] = ch2_off_code;
  assign code2[2] = ch3_off_code;
  assign code2[3] = ch4_off_code;

  // two-bit codes map to a fixed table of tick counts
  // one process fills every lane, so each decode array keeps a single driver
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      unique case (code2[i])
        2'h1: off_ticks[i] = `SBOT_OFF_06_TICKS;
        2'h2: off_ticks[i] = `SBOT_OFF_12_TICKS;
        2'h3: off_ticks[i] = `SBOT_OFF_18_TICKS;
        default: off_ticks[i] = 8'h00;
      endcase
      off_dis[i] = (code2[i] == `SBOT_CODE_DIS2);
      off_hold[i] = 1'b0;
    end
    // sink six: seven-bit code n gives n-1 tenths of a second, two ticks each
    if (ch6_off_code == `SBOT_CODE_DIS7 || ch6_off_code == `SBOT_CODE_ZERO7) begin
      off_ticks[4] = 8'h00;
    end else begin
      off_ticks[4] = {ch6_off_code - 7'h01, 1'b0};
    end
    off_dis[4] = (ch6_off_code == `SBOT_CODE_DIS7);
    off_hold[4] = (ch6_off_code == `SBOT_CODE_HOLD7);
  end

  // --------------------------------------------------
  // channels
  // --------------------------------------------------
  // sink_on_duration counts in ticks directly, 0..15 steps of 50 ms
  for (genvar g = 0; g < 5; g++) begin : g_ch
    sbot_chan u_chan (
      .sys_clk(sys_clk),
      .rst(rst),
      .tick(tick),
      .enable(sink_enable[g]),
      .on_ticks(sink_on_duration),
      .off_ticks(off_ticks[g]),
      .off_dis(off_dis[g]),
      .off_hold(off_hold[g]),
      .sink_on(sink_on[g])
    );
  end

  // --------------------------------------------------
  // assertions
  // --------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_ch1_dis_held;
    (sink_enable[0] && ch1_off_code == 2'h0) [*3];
  endsequence
  property p_dis_stays_on;
    s_ch1_dis_held |-> sink_on[0];
  endproperty
  a_dis_stays_on: assert property (p_dis_stays_on) else $error("disabled off code blinked");

  property p_shared_write;
    (reg_wr && reg_addr == 8'h1d) |=> ch4_off_code == $past(reg_wdata[7:6])
      && ch1_off_code == $past(reg_wdata[1:0]);
  endproperty
  a_shared_write: assert property (p_shared_write) else $error("shared field mislaid");

  property p_code_table;
    (ch2_off_code == 2'h2) |-> off_ticks[1] == 8'h18;
  endproperty
  a_code_table: assert property (p_code_table) else $error("1.2 s code wrong");

  property p_off_then_on;
    ($fell(sink_on[0]) && sink_enable[0]) ##1 sink_enable[0] |-> !sink_on[0];
  endproperty
  a_off_then_on: assert property (p_off_then_on) else $error("off phase too short");

  property p_reserved_bit;
    (reg_wr && reg_addr == 8'h1e) |=> sink6_off_timer_r[7] == 1'b0
      && ch6_off_code == $past(reg_wdata[6:0]);
  endproperty
  a_reserved_bit: assert property (p_reserved_bit) else $error("reserved bit stored");

  property p_step_decode;
    (ch6_off_code == 7'h7e) |-> off_ticks[4] == 8'hfa;
  endproperty
  a_step_decode: assert property (p_step_decode) else $error("12.5 s code wrong");

  property p_zero_code;
    (ch6_off_code == 7'h01) |-> off_ticks[4] == 8'h00 && !off_dis[4] && !off_hold[4];
  endproperty
  a_zero_code: assert property (p_zero_code) else $error("zero second code wrong");

  property p_hold_decode;
    (ch6_off_code == 7'h7f) |-> off_hold[4] && !off_dis[4];
  endproperty
  a_hold_decode: assert property (p_hold_decode) else $error("hold code not decoded");

  property p_short_code;
    (ch1_off_code == 2'h1) |-> off_ticks[0] == 8'h0c;
  endproperty
  a_short_code: assert property (p_short_code) else $error("0.6 s code wrong");

  property p_long_code;
    (ch3_off_code == 2'h3) |-> off_ticks[2] == 8'h24;
  endproperty
  a_long_code: assert property (p_long_code) else $error("1.8 s code wrong");

  sequence s_hold_dark;
    (sink_enable[4] && ch6_off_code == 7'h7f && !sink_on[4]) [*2];
  endsequence
  property p_hold_off;
    s_hold_dark ##1 sink_enable[4] |-> !sink_on[4];
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("held sink relit");

  property p_restart_on;
    $rose(sink_enable[1]) ##1 sink_enable[1] |-> sink_on[1];
  endproperty
  a_restart_on: assert property (p_restart_on) else $error("no on phase at enable");

  property p_disable_dark;
    !sink_enable[2] |=> !sink_on[2];
  endproperty
  a_disable_dark: assert property (p_disable_dark) else $error("disabled sink lit");
endmodule
`default_nettype wire

// >>> tb/sink_blink_off_timer_tb.sv
// self-checking bench for the blink off timers and their two registers
`timescale 1ns/1ns
`default_nettype none
`include "sbot_cfg.svh"
module sink_blink_off_timer_tb;
  // --------------------------------------------------------------
  // signals and design
  // --------------------------------------------------------------
  localparam int T = 10; // short tick keeps blink phases to at most a few thousand cycles
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_rdata;
  logic [4:0] sink_enable = 5'h00;
  logic [3:0] sink_on_duration = 4'h0;
  logic [4:0] sink_on;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  sbot_top #(.TICK_CYCLES(T)) dut_u (
    .sys_clk(sys_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rdata(reg_rdata),
    .sink_enable(sink_enable),
    .sink_on_duration(sink_on_duration),
    .sink_on(sink_on)
  );
  always #5 sys_clk = ~sys_clk;
  // --------------------------------------------------------------
  // report, compare and access tasks
  // --------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard: the whole sequence needs well under this many cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // phase lengths may lose up to one tick, since a started tick counts whole
  task automatic chk_len(input int got, input int lo, input int hi);
    n_tests++;
    if (got < (lo < 1 ? 1 : lo) || got > hi) begin
      error_cnt++;
      $display("wrong value at %0t: phase %0d cycles, window %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    @(negedge sys_clk);
  endtask
  // read data is registered, so it is settled one edge after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    @(negedge sys_clk);
    chk8(reg_rdata, exp);
  endtask
  // enable one sink alone, skip its first on phase, then time off and on phases
  task automatic blink(input int b, input logic [3:0] on, input int offt);
    int n;
    int lo;
    int hi;
    sink_on_duration = on;
    sink_enable = 5'h01 << b;
    n = 0;
    lo = 0;
    hi = 0;
    // wait out the idle cycle, then the first on phase, which starts off a tick boundary
    while (sink_on[b] !== 1'b1 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    while (sink_on[b] === 1'b1 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    while (sink_on[b] === 1'b0 && lo < 3000) begin
      @(negedge sys_clk);
      lo++;
    end
    while (sink_on[b] === 1'b1 && hi < 3000) begin
      @(negedge sys_clk);
      hi++;
    end
    chk_len(lo, (offt - 1) * T, offt * T + 2);
    chk_len(hi, (on - 1) * T, on * T + 2);
    sink_enable = 5'h00;
    @(negedge sys_clk);
  endtask
  // --------------------------------------------------------------
  // test sequence
  // --------------------------------------------------------------
  initial begin
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    rd(`SBOT_ADDR_SINKS1_4, `SBOT_RST_SINKS1_4);
    rd(`SBOT_ADDR_SINK6, `SBOT_RST_SINK6);
    rd(8'h1c, 8'h00);
    wr(8'h1c, 8'h5a);
    rd(8'h1c, 8'h00);
    wr(`SBOT_ADDR_SINKS1_4, 8'h93);
    rd(`SBOT_ADDR_SINKS1_4, 8'h93);
    wr(`SBOT_ADDR_SINK6, 8'hff);
    rd(`SBOT_ADDR_SINK6, 8'h7f);
    // all codes disabled: every enabled sink must stay lit
    wr(`SBOT_ADDR_SINKS1_4, 8'h00);
    wr(`SBOT_ADDR_SINK6, 8'h00);
    sink_enable = 5'h1f;
    repeat (2) @(negedge sys_clk);
    repeat (30) begin
      repeat (T) @(negedge sys_clk);
      chk8({3'h0, sink_on}, 8'h1f);
    end
    sink_enable = 5'h00;
    @(negedge sys_clk);
    // each lane alone, so a field in the wrong place never blinks
    for (int i = 0; i < 4; i++) begin
      wr(`SBOT_ADDR_SINKS1_4, 8'(((i % 3) + 1) << (2 * i)));
      blink(i, 4'h2, 12 * ((i % 3) + 1));
    end
    // seven-bit codes: zero time, first step, last step
    // fade-out lives outside this block, so the zero-off caution has nothing to guard here
    wr(`SBOT_ADDR_SINK6, 8'h01);
    blink(4, 4'h3, 0);
    wr(`SBOT_ADDR_SINK6, 8'h02);
    blink(4, 4'h0, 2);
    wr(`SBOT_ADDR_SINK6, 8'h7e);
    blink(4, 4'hf, 250);
    // hold code: one on phase, then dark until re-enabled
    wr(`SBOT_ADDR_SINK6, 8'h7f);
    sink_on_duration = 4'h2;
    sink_enable = 5'h10;
    repeat (3) @(negedge sys_clk);
    chk8({7'h0, sink_on[4]}, 8'h01);
    repeat (60) @(negedge sys_clk);
    chk8({7'h0, sink_on[4]}, 8'h00);
    repeat (2000) @(negedge sys_clk);
    chk8({7'h0, sink_on[4]}, 8'h00);
    sink_enable = 5'h00;
    @(negedge sys_clk);
    sink_enable = 5'h10;
    repeat (3) @(negedge sys_clk);
    chk8({7'h0, sink_on[4]}, 8'h01);
    give_verdict();
  end
endmodule
`default_nettype wire
